// [cpa_top.sv]
// sequencer, accumulator and result registers of the current/power monitor
// Notes on behaviour
// - one converter, shunt then bus, never both
// - compute only after shunt and bus pair
// - power uses latest current and newest bus
// - zero calibration gives zero power
// - accumulate every result unless averaging is one
// - load averages after final sample of set
// - arithmetic overlaps the next conversion; after the last pair of a set it adds three cycles
// - continuous mode repeats shunt then bus forever
// - done flag only after all work finished
`timescale 1ns/100ps
`include "cpa_defines.svh"
module cpa_top #(
  parameter int AVG_MAX = `CPA_AVG_MAX
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // configuration from the register side
  input wire logic [2:0] op_mode,
  input wire logic mode_write,
  input wire logic [15:0] cal_value,
  input wire logic [10:0] avg_count,
  input wire logic flag_clear,
  // converter handshake
  output logic conv_start,
  output cpa_pkg::cpa_kind_t conv_kind,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  // results for the host
  output logic signed [31:0] current_out,
  output logic [31:0] power_out,
  output logic [15:0] shunt_out,
  output logic [15:0] bus_out,
  output logic conversion_done_flag
);
  import cpa_pkg::*;

  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  // refused while elaborating: the count port is 11 bits and zero means one
  if (AVG_MAX < 1 || AVG_MAX > 2047) begin : g_avg_check
    $error("cpa_top: AVG_MAX out of range");
  end

  cpa_calc_if cx();

  cpa_calc u_calc (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .cx(cx)
  );

  // ------------------------------------------------------------
  // sequencer state
  // ------------------------------------------------------------
  cpa_state_t state, next_state;
  logic start_q, next_start_q;         // pulse to the converter
  logic [15:0] shunt_s, next_shunt_s;  // last shunt sample
  logic [15:0] bus_s, next_bus_s;      // last bus sample
  logic calc_go, next_calc_go;         // pair complete pulse
  logic [10:0] samp_cnt, next_samp_cnt; // pairs issued in this set
  logic set_last, next_set_last;        // current pair closes the set
  logic [10:0] avg_eff;

  // averaging of zero is treated as one; counts above the limit are cut to
  // it so the accumulator can never overflow
  assign avg_eff = (avg_count == 11'h000) ? 11'h001 :
                   (avg_count > 11'(AVG_MAX)) ? 11'(AVG_MAX) : avg_count;

  // sequencer next state: one converter, shunt then bus
  always_comb begin
    next_state = state;
    next_start_q = 1'b0;
    next_shunt_s = shunt_s;
    next_bus_s = bus_s;
    next_calc_go = 1'b0;
    next_samp_cnt = samp_cnt;
    next_set_last = set_last;
    case (state)
      CPA_IDLE: begin
        // a write of an active mode starts a set
        if (mode_write && op_mode != `CPA_MODE_OFF) begin
          next_state = CPA_CONV_SHUNT;
          next_start_q = 1'b1;
          next_samp_cnt = 11'h001;
          next_set_last = (avg_eff == 11'h001);
        end
      end
      CPA_CONV_SHUNT: begin
        if (conv_done) begin
          next_shunt_s = conv_data;
          next_state = CPA_CONV_BUS;
          next_start_q = 1'b1;
        end
      end
      CPA_CONV_BUS: begin
        if (conv_done) begin
          next_bus_s = conv_data;
          next_calc_go = 1'b1;
          // next conversion starts at once, arithmetic runs beside it
          if (!set_last) begin
            next_state = CPA_CONV_SHUNT;
            next_start_q = 1'b1;
            next_samp_cnt = 11'(samp_cnt + 11'h001);
            next_set_last = (11'(samp_cnt + 11'h001) == avg_eff);
          end else if (op_mode == `CPA_MODE_CONT) begin
            next_state = CPA_CONV_SHUNT;
            next_start_q = 1'b1;
            next_samp_cnt = 11'h001;
            next_set_last = (avg_eff == 11'h001);
          end else begin
            next_state = CPA_IDLE;
          end
        end
      end
      default: begin
        next_state = CPA_IDLE;
      end
    endcase
    // a power-down write stops conversions at the pair boundary is not
    // waited for: the set is abandoned and results stay as they were
    if (mode_write && op_mode == `CPA_MODE_OFF) begin
      next_state = CPA_IDLE;
      next_start_q = 1'b0;
    end
  end

  // sequencer registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= CPA_IDLE;
      start_q <= 1'b0;
      shunt_s <= 16'h0;
      bus_s <= 16'h0;
      calc_go <= 1'b0;
      samp_cnt <= 11'h0;
      set_last <= 1'b0;
    end else begin
      state <= next_state;
      start_q <= next_start_q;
      shunt_s <= next_shunt_s;
      bus_s <= next_bus_s;
      calc_go <= next_calc_go;
      samp_cnt <= next_samp_cnt;
      set_last <= next_set_last;
    end
  end

  assign conv_start = start_q;
  assign conv_kind = (state == CPA_CONV_BUS) ? CPA_SMP_BUS : CPA_SMP_SHUNT;
  assign cx.start = calc_go;
  assign cx.shunt = shunt_s;
  assign cx.bus = bus_s;
  assign cx.cal = cal_value;

  // ------------------------------------------------------------
  // accumulator and result registers
  // ------------------------------------------------------------
  logic signed [42:0] acc_cur, next_acc_cur; // wide enough for 2047 adds
  logic [42:0] acc_pwr, next_acc_pwr;
  logic [10:0] acc_n, next_acc_n;            // results added so far
  logic [10:0] set_n, next_set_n;            // averaging count of set
  logic signed [31:0] cur_o, next_cur_o;
  logic [31:0] pwr_o, next_pwr_o;
  logic [15:0] sh_o, next_sh_o;
  logic [15:0] bu_o, next_bu_o;
  logic flag, next_flag;
  logic signed [42:0] sum_cur;
  logic [42:0] sum_pwr;
  logic last_res;

  // next values: sum every result, divide at the end of the set
  always_comb begin
    sum_cur = acc_cur + 43'(cx.cur);
    sum_pwr = acc_pwr + 43'(cx.pwr);
    last_res = (11'(acc_n + 11'h001) >= set_n);
    next_acc_cur = acc_cur;
    next_acc_pwr = acc_pwr;
    next_acc_n = acc_n;
    next_set_n = set_n;
    next_cur_o = cur_o;
    next_pwr_o = pwr_o;
    next_sh_o = sh_o;
    next_bu_o = bu_o;
    next_flag = flag;
    // a status read or an active mode write clears the flag; a set below
    // still wins, and a clear beside a mere intermediate result is kept
    if (flag_clear || (mode_write && op_mode != `CPA_MODE_OFF)) begin
      next_flag = 1'b0;
    end
    // latch averaging count when the accumulator is empty
    if (acc_n == 11'h000) begin
      next_set_n = avg_eff;
    end
    if (cx.done) begin
      if (last_res) begin
        // final result: divide and publish
        next_cur_o = 32'(sum_cur / $signed({32'h0, set_n}));
        next_pwr_o = 32'(sum_pwr / {32'h0, set_n});
        next_sh_o = shunt_s;
        next_bu_o = bus_s;
        next_acc_cur = 43'h0;
        next_acc_pwr = 43'h0;
        next_acc_n = 11'h000;
        next_flag = 1'b1;
      end else begin
        next_acc_cur = sum_cur;
        next_acc_pwr = sum_pwr;
        next_acc_n = 11'(acc_n + 11'h001);
      end
    end
    // an abandoned set discards partial sums
    if (mode_write && !cx.done) begin
      next_acc_cur = 43'h0;
      next_acc_pwr = 43'h0;
      next_acc_n = 11'h000;
    end
  end

  // result registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_cur <= 43'h0;
      acc_pwr <= 43'h0;
      acc_n <= 11'h0;
      set_n <= 11'h1;
      cur_o <= 32'h0;
      pwr_o <= 32'h0;
      sh_o <= 16'h0;
      bu_o <= 16'h0;
      flag <= 1'b0;
    end else begin
      acc_cur <= next_acc_cur;
      acc_pwr <= next_acc_pwr;
      acc_n <= next_acc_n;
      set_n <= next_set_n;
      cur_o <= next_cur_o;
      pwr_o <= next_pwr_o;
      sh_o <= next_sh_o;
      bu_o <= next_bu_o;
      flag <= next_flag;
    end
  end

  assign current_out = cur_o;
  assign power_out = pwr_o;
  assign shunt_out = sh_o;
  assign bus_out = bu_o;
  assign conversion_done_flag = flag;
endmodule

// [cpa_defines.svh]
// shared constants for the current and power accumulator
`ifndef CPA_DEFINES_SVH
`define CPA_DEFINES_SVH
// -----------------------------------------------------------------
// operating modes
// -----------------------------------------------------------------
`define CPA_MODE_OFF 3'h0
`define CPA_MODE_SINGLE 3'h1
`define CPA_MODE_CONT 3'h7
// -----------------------------------------------------------------
// arithmetic shapes
// -----------------------------------------------------------------
`define CPA_SMP_W 16
`define CPA_CUR_SHIFT 11
`define CPA_PWR_SHIFT 13
`define CPA_AVG_MAX 1024
`endif

// [cpa_pkg.sv]
// types for the current and power accumulator
package cpa_pkg;
  // sample kinds coming out of the shared converter
  typedef enum logic {
    CPA_SMP_SHUNT,
    CPA_SMP_BUS
  } cpa_kind_t;
  // sequencer states
  typedef enum logic [1:0] {
    CPA_IDLE,
    CPA_CONV_SHUNT,
    CPA_CONV_BUS
  } cpa_state_t;
endpackage

// [cpa_calc_if.sv]
// carrier between the sequencer and the arithmetic unit
`timescale 1ns/100ps
interface cpa_calc_if;
  logic start;                // one-cycle request: shunt and bus pair ready
  logic signed [15:0] shunt;  // shunt sample of the pair
  logic [15:0] bus;           // bus sample of the pair
  logic [15:0] cal;           // calibration value
  logic done;                 // one-cycle pulse: results valid
  logic signed [31:0] cur;    // computed current
  logic [31:0] pwr;           // computed power
  modport seq (output start, output shunt, output bus, output cal,
               input done, input cur, input pwr);
  modport calc (input start, input shunt, input bus, input cal,
                output done, output cur, output pwr);
endinterface

// [cpa_calc.sv]
// two-stage current then power arithmetic unit
`timescale 1ns/100ps
`include "cpa_defines.svh"
module cpa_calc (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // link to the sequencer
  cpa_calc_if.calc cx
);
  import cpa_pkg::*;
  // ------------------------------------------------------------
  // pipeline state
  // ------------------------------------------------------------
  logic stage1, next_stage1;            // current stage busy
  logic signed [31:0] cur, next_cur;    // latest current
  logic [15:0] bus_hold, next_bus_hold; // bus sample for stage two
  logic [15:0] cal_hold, next_cal_hold; // calibration copy
  logic done, next_done;
  logic [31:0] pwr, next_pwr;
  logic signed [47:0] cur_prod;
  logic [47:0] pwr_prod;
  logic [31:0] cur_mag;

  // next values: current first, power a cycle later from that current
  always_comb begin
    cur_prod = 48'(cx.shunt) * $signed({1'b0, cx.cal});
    cur_mag = cur[31] ? 32'(-cur) : cur;
    pwr_prod = 48'(cur_mag) * 48'(bus_hold);
    next_stage1 = cx.start;
    next_cur = cur;
    next_bus_hold = bus_hold;
    next_cal_hold = cal_hold;
    next_done = 1'b0;
    next_pwr = pwr;
    if (cx.start) begin
      next_cur = 32'(cur_prod >>> `CPA_CUR_SHIFT);
      next_bus_hold = cx.bus;
      next_cal_hold = cx.cal;
    end
    if (stage1) begin
      // power uses the current just formed and the newest bus sample
      next_pwr = (cal_hold == 16'h0000) ? 32'h0 : 32'(pwr_prod >> `CPA_PWR_SHIFT);
      next_done = 1'b1;
    end
  end

  // registers only
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stage1 <= 1'b0;
      cur <= 32'h0;
      bus_hold <= 16'h0;
      cal_hold <= 16'h0;
      done <= 1'b0;
      pwr <= 32'h0;
    end else begin
      stage1 <= next_stage1;
      cur <= next_cur;
      bus_hold <= next_bus_hold;
      cal_hold <= next_cal_hold;
      done <= next_done;
      pwr <= next_pwr;
    end
  end

  assign cx.done = done;
  assign cx.cur = cur;
  assign cx.pwr = pwr;
endmodule

// [cpa_top_props.sv]
// concurrent checks on the ports of the current/power accumulator
`timescale 1ns/100ps
module cpa_top_props
  import cpa_pkg::*;
#(
  parameter int AVG_MAX = 1024
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // configuration
  input wire logic [2:0] op_mode,
  input wire logic mode_write,
  input wire logic [15:0] cal_value,
  input wire logic [10:0] avg_count,
  input wire logic flag_clear,
  // converter handshake
  input wire logic conv_start,
  input wire cpa_pkg::cpa_kind_t conv_kind,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  // results
  input wire logic signed [31:0] current_out,
  input wire logic [31:0] power_out,
  input wire logic [15:0] shunt_out,
  input wire logic [15:0] bus_out,
  input wire logic conversion_done_flag
);
  // -----------------------------------------------------------------
  // clocking and sequences
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // a conversion the block started and has neither seen finish nor abandoned;
  // an idle block shows the shunt kind, so a late result after a stop must
  // not be taken for a shunt result of a live pair
  logic in_conv;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      in_conv <= 1'b0;
    end else if (mode_write && op_mode == 3'h0) begin
      in_conv <= 1'b0;
    end else if (conv_start) begin
      in_conv <= 1'b1;
    end else if (conv_done) begin
      in_conv <= 1'b0;
    end
  end
  // a shunt result taken with no abort pending
  sequence s_shunt_done;
    conv_done && in_conv && conv_kind == CPA_SMP_SHUNT && !mode_write;
  endsequence
  // the bus conversion of the same pair begins
  sequence s_bus_start;
    conv_start && conv_kind == CPA_SMP_BUS;
  endsequence
  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  chk_one_conv: assert property (conv_start |=> !conv_start)
    else $error("second start while converting");
  chk_kind_stable: assert property ((!conv_done && !mode_write) |=> $stable(conv_kind))
    else $error("sample kind changed mid conversion");
  chk_bus_after: assert property (s_shunt_done |=> s_bus_start)
    else $error("bus conversion did not follow shunt at once");
  chk_cont_repeat: assert property ((conv_done && conv_kind == CPA_SMP_BUS &&
    op_mode == 3'h7 && !mode_write) |=> (conv_start && conv_kind == CPA_SMP_SHUNT))
    else $error("continuous mode did not restart shunt");
  // flag rises four cycles after the bus sample, never sooner
  chk_flag_time: assert property ($rose(conversion_done_flag) |->
    ($past(conv_done, 4) && $past(conv_kind, 4) == CPA_SMP_BUS))
    else $error("flag rose without a finished pair");
  chk_result_hold: assert property (($changed(current_out) || $changed(power_out))
    |-> ($past(conv_done, 4) && $past(conv_kind, 4) == CPA_SMP_BUS))
    else $error("results changed outside a set end");
  chk_zero_cal: assert property ((($changed(current_out) || $changed(power_out))
    && $past(cal_value, 3) == 16'h0) |-> power_out == 32'h0)
    else $error("power not zero with zero calibration");
  // set beats clear, so only a clear with no set in flight must drop it
  chk_flag_clear: assert property ((flag_clear && !$past(conv_done, 3))
    |=> !conversion_done_flag)
    else $error("flag survived a clear");
endmodule
bind cpa_top cpa_top_props #(.AVG_MAX(AVG_MAX)) i_cpa_top_props (.*);

// [cpa_conv_model.sv]
// behavioural model of the shared converter feeding the block
`timescale 1ns/100ps
module cpa_conv_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // handshake with the block
  input wire logic conv_start,
  input wire cpa_pkg::cpa_kind_t conv_kind,
  output logic conv_done,
  output logic [15:0] conv_data,
  // scenario controls
  input wire logic [15:0] shunt_val,
  input wire logic [15:0] bus_val,
  input wire logic [7:0] dly,
  output int n_bus
);
  import cpa_pkg::*;
  logic busy; // one conversion in flight
  logic [7:0] cnt; // cycles left
  cpa_kind_t kind; // kind latched at start
  initial conv_data = 16'h0;
  initial conv_done = 1'b0;
  // -----------------------------------------------------------------
  // conversion timing
  // -----------------------------------------------------------------
  // data toggles when not valid so a stale sample is never read as good
  always @(posedge clk_sys) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (sys_rst) begin
      busy <= 1'b0;
      n_bus <= 0;
    end else if (conv_start) begin
      busy <= 1'b1;
      cnt <= dly;
      kind <= conv_kind;
    end else if (busy && cnt == 8'h0) begin
      busy <= 1'b0;
      conv_done <= 1'b1;
      conv_data <= (kind == CPA_SMP_BUS) ? bus_val : shunt_val;
      n_bus <= n_bus + int'(kind == CPA_SMP_BUS);
    end else if (busy) begin
      cnt <= cnt - 8'h1;
    end
  end
endmodule

// [tb_top.sv]
// self-checking bench for the current/power accumulator
`timescale 1ns/100ps
module tb_top;
  logic clk_sys, sys_rst, mode_write, flag_clear, conv_start, conv_done, flag;
  logic [2:0] op_mode;
  logic [15:0] cal_value, conv_data, shunt_out, bus_out, shunt_val, bus_val;
  logic [10:0] avg_count;
  logic [7:0] dly;
  logic signed [31:0] current_out;
  logic [31:0] power_out;
  cpa_pkg::cpa_kind_t conv_kind;
  int n_bus, n_errors, n_tests, cycles, n0, c0;
  // -----------------------------------------------------------------
  // instances
  // -----------------------------------------------------------------
  cpa_top i_cpa_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .op_mode(op_mode),
    .mode_write(mode_write), .cal_value(cal_value), .avg_count(avg_count),
    .flag_clear(flag_clear), .conv_start(conv_start), .conv_kind(conv_kind),
    .conv_done(conv_done), .conv_data(conv_data), .current_out(current_out),
    .power_out(power_out), .shunt_out(shunt_out), .bus_out(bus_out),
    .conversion_done_flag(flag));
  cpa_conv_model i_cpa_conv_model (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .conv_start(conv_start), .conv_kind(conv_kind), .conv_done(conv_done),
    .conv_data(conv_data), .shunt_val(shunt_val), .bus_val(bus_val), .dly(dly),
    .n_bus(n_bus));
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task check(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one configuration write with the mode and count as levels
  task start_set(logic [2:0] m, logic [10:0] a);
    @(negedge clk_sys) op_mode = m;
    avg_count = a;
    mode_write = 1'b1;
    @(negedge clk_sys) mode_write = 1'b0;
  endtask
  // bounded wait for the sticky flag
  task wait_flag;
    for (int i = 0; i < 3000 && flag !== 1'b1; i++) @(negedge clk_sys);
    // a flag that never came counts against the run
    if (flag !== 1'b1) n_errors++;
  endtask
  task finish_test;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  // negative shunt, one pair: magnitude of current scales power
  task t_single;
    shunt_val = 16'hfc18;
    bus_val = 16'h2000;
    cal_value = 16'h0800;
    dly = 8'h0;
    n0 = n_bus;
    start_set(3'h1, 11'h1);
    wait_flag();
    check("current", current_out, 32'hfffffc18);
    check("power", power_out, 32'h3e8);
    check("bus", bus_out, 16'h2000);
    check("shunt", shunt_out, 16'hfc18);
    check("pairs", n_bus - n0, 1);
  endtask
  // four pairs, slow converter; outputs hold until the set ends
  task t_average;
    shunt_val = 16'h0400;
    bus_val = 16'h4000;
    cal_value = 16'h1000;
    dly = 8'h5;
    n0 = n_bus;
    start_set(3'h1, 11'h4);
    c0 = cycles;
    for (int i = 0; i < 500 && n_bus < n0 + 2; i++) @(negedge clk_sys);
    repeat (6) @(negedge clk_sys);
    check("held", power_out, 32'h3e8);
    check("early flag", flag, 1'b0);
    wait_flag();
    check("pairs", n_bus - n0, 4);
    check("avg current", current_out, 32'h800);
    check("avg power", power_out, 32'h1000);
    // eight back-to-back conversions of dly+3 cycles, then three to publish
    check("set time", cycles - c0, 67);
  endtask
  // zero calibration forces power to zero; a zero count runs one pair
  task t_zero_cal;
    cal_value = 16'h0;
    n0 = n_bus;
    start_set(3'h1, 11'h0);
    wait_flag();
    check("zero power", power_out, 32'h0);
    check("zero count pairs", n_bus - n0, 1);
  endtask
  // continuous run, then stop and clear the flag
  task t_cont;
    dly = 8'h2;
    n0 = n_bus;
    start_set(3'h7, 11'h1);
    for (int i = 0; i < 500 && n_bus < n0 + 3; i++) @(negedge clk_sys);
    check("repeats", n_bus >= n0 + 3, 1'b1);
    start_set(3'h0, 11'h1);
    repeat (12) @(negedge clk_sys);
    flag_clear = 1'b1;
    @(negedge clk_sys) flag_clear = 1'b0;
    n0 = n_bus;
    repeat (30) @(negedge clk_sys);
    check("cleared", flag, 1'b0);
    check("stopped", n_bus - n0, 0);
  endtask
  // -----------------------------------------------------------------
  // clock, timeout and main sequence
  // -----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // the whole run needs well under 5000 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    {sys_rst, mode_write, flag_clear, op_mode, cal_value} = {3'b100, 3'h0, 16'h0};
    {avg_count, shunt_val, bus_val, dly} = {11'h1, 16'h0, 16'h0, 8'h0};
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_single();
    t_average();
    t_zero_cal();
    t_cont();
    finish_test();
  end
endmodule
